// *** src/dmau_core.sv ***
/*
  Data-memory address unit: direct, full and access-bank addressing,
  three indirect pointers with five operand slots each, status flag
  write protection, and an APB view of its registers.
  Assumes the decoder presents one request per cycle on req, with the
  flag results of the same instruction on flags, all on clock.
*/
// What this block does
// RULE_01: direct address is bank selector low nibble over opcode byte.
// RULE_02: bank selector upper nibble reads zero, writes to it ignored.
// RULE_03: unimplemented bank reads zero, drops writes, flags still update.
// RULE_04: sixteen banks of 256 bytes each.
// RULE_05: file-to-file move uses its full 12-bit address, no bank.
// RULE_06: access bit clear to access bank ignores the bank selector.
// RULE_07: three 12-bit pointers, each a high and a low byte.
// RULE_08: indirect operand reaches the location held in its pointer.
// RULE_09: indirect access to an indirect operand reads zero, writes nothing.
// RULE_10: five slots: plain, post-decrement, post-increment after access.
// RULE_11: pre-increment steps first and uses the stepped address.
// RULE_12: indexed slot adds signed working value, changes neither.
// RULE_13: pointer steps never touch the status flags.
// RULE_14: steps act on all 12 bits with carry into high byte.
// RULE_15: a write to the pointer's own byte beats its step.
// RULE_16: status as destination keeps flags set by the instruction.
// RULE_17: carry and nibble carry are inverted borrows on subtraction.
// RULE_18: access bit chooses selected bank or access bank.
// RULE_19: access bank is bank 0 low 96 then bank 15 upper 160.
// RULE_20: pre-increment keeps the stepped pointer afterwards.
`timescale 1ns/1ps
module dmau_core
  import dmau_pkg::*;
#(
  parameter int IMPL_BANKS = 16
) (
  input wire logic clock, // 250 MHz device clock
  input wire logic rstn, // asynchronous reset, active low
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire dmau_pkg::dmau_req_s req, // operand access from decoder
  input wire dmau_pkg::dmau_flags_s flags, // flag results of the ALU
  input wire logic loadBankValid, // load bank literal instruction
  input wire logic [7:0] loadBankLit, // its literal
  output logic [7:0] rdData, // operand read data
  output logic rdValid, // read data valid pulse
  output logic [11:0] effAddr, // last effective address
  output logic [7:0] statusOut // status register
);
  import dmau_pkg::*;

  function automatic logic isIndirect(input logic [11:0] a);
    return (a >= PTR_BASE) && (a < PTR_END) && (a[2:0] <= SLOT_INDEXED);
  endfunction : isIndirect

  function automatic logic isPtrByte(input logic [11:0] a);
    return (a >= PTR_BASE) && (a < PTR_END) &&
      ((a[2:0] == SLOT_LOW) || (a[2:0] == SLOT_HIGH));
  endfunction : isPtrByte

  logic [3:0] bankSel_reg;
  logic [7:0] work_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] rdData_reg;
  logic rdValid_reg;
  logic [11:0] effAddr_reg;

  logic [11:0] ptrVal [0:NUM_PTRS-1];
  logic [NUM_PTRS-1:0] ptrInc;
  logic [NUM_PTRS-1:0] ptrDec;
  logic [NUM_PTRS-1:0] ptrWrLo;
  logic [NUM_PTRS-1:0] ptrWrHi;
  logic [NUM_PTRS-1:0] ptrWrFull;
  logic [11:0] ptr0;

  logic [11:0] dirAddr;
  logic opIsInd;
  logic [1:0] opPtr;
  dmau_slot_e opSlot;
  logic [11:0] ptrBase;
  logic [11:0] indTarget;
  logic [11:0] tgt;
  logic selfRef;
  logic coreWr;
  logic [7:0] readMux;
  logic [7:0] ramRd;
  logic [4:0] flagIn;
  logic apbAccess;
  logic apbWr;
  logic apbMapped;

  // operand address before any indirection
  always_comb begin
    if (req.fullMode) begin
      dirAddr = req.fullAddr; // RULE_05
    end else if (!req.accessBit) begin // RULE_06
      if (req.fileAddr < ACCESS_SPLIT) begin
        dirAddr = {ACCESS_LOW_BANK, req.fileAddr}; // RULE_19
      end else begin
        dirAddr = {ACCESS_HIGH_BANK, req.fileAddr}; // RULE_19
      end
    end else begin
      dirAddr = {bankSel_reg, req.fileAddr}; // RULE_01 RULE_18
    end
  end

  assign opIsInd = isIndirect(dirAddr);
  assign opPtr = dirAddr[4:3];
  assign opSlot = dmau_slot_e'(dirAddr[2:0]);
  assign ptrBase = ptrVal[opPtr];
  assign ptr0 = ptrVal[0];

  // access address of an indirect slot
  always_comb begin
    case (opSlot)
      SLOT_PREINC: indTarget = ptrBase + 12'h001; // RULE_11
      SLOT_INDEXED: indTarget = ptrBase +
        {{4{work_reg[7]}}, work_reg}; // RULE_12
      default: indTarget = ptrBase; // RULE_08 RULE_10
    endcase
  end

  assign tgt = opIsInd ? indTarget : dirAddr; // RULE_08
  assign selfRef = opIsInd && isIndirect(indTarget); // RULE_09
  assign coreWr = req.valid && req.write && !selfRef; // RULE_09

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PTRS; gi++) begin : gPtr
      logic hitByte;
      logic hitStep;
      assign hitByte = coreWr && isPtrByte(tgt) && (tgt[4:3] == 2'(gi));
      assign ptrWrLo[gi] = hitByte && (tgt[2:0] == SLOT_LOW); // RULE_15
      assign ptrWrHi[gi] = hitByte && (tgt[2:0] == SLOT_HIGH); // RULE_15
      assign hitStep = req.valid && opIsInd && (opPtr == 2'(gi));
      assign ptrInc[gi] = hitStep &&
        ((opSlot == SLOT_POSTINC) || (opSlot == SLOT_PREINC)); // RULE_20
      assign ptrDec[gi] = hitStep && (opSlot == SLOT_POSTDEC); // RULE_10
      assign ptrWrFull[gi] = apbWr &&
        (paddr == APB_PTR0 + 12'(4 * gi));
      dmau_pointer uPtr (
        .clock(clock),
        .rstn(rstn),
        .wrLo(ptrWrLo[gi]),
        .wrHi(ptrWrHi[gi]),
        .wrData(req.wrData),
        .wrFull(ptrWrFull[gi]),
        .fullData(pwdata[11:0]),
        .stepInc(ptrInc[gi]),
        .stepDec(ptrDec[gi]),
        .value(ptrVal[gi])
      );
    end
  endgenerate

  dmau_ram #(.IMPL_BANKS(IMPL_BANKS)) uRam (
    .clock(clock),
    .wrEn(coreWr && (tgt < SFR_BASE)),
    .addr(tgt),
    .wrData(req.wrData),
    .rdData(ramRd)
  );

  // operand read data
  always_comb begin
    if (selfRef) begin
      readMux = 8'h00; // RULE_09
    end else if (tgt < SFR_BASE) begin
      readMux = ramRd; // RULE_03
    end else if (tgt == STATUS_ADDR) begin
      readMux = status_reg;
    end else if (tgt == WORK_ADDR) begin
      readMux = work_reg;
    end else if (tgt == BANKSEL_ADDR) begin
      readMux = {4'h0, bankSel_reg}; // RULE_02
    end else if (isPtrByte(tgt) && (tgt[2:0] == SLOT_LOW)) begin
      readMux = ptrVal[tgt[4:3]][7:0];
    end else if (isPtrByte(tgt)) begin
      readMux = {4'h0, ptrVal[tgt[4:3]][11:8]};
    end else begin
      readMux = 8'h00;
    end
  end

  // APB slave, stalled while the core owns the cycle
  assign apbAccess = psel && penable && !req.valid;
  assign pready = !req.valid;
  assign apbMapped = (paddr == APB_BANKSEL) || (paddr == APB_WORK) ||
    (paddr == APB_STATUS) || (paddr == APB_PTR0) ||
    (paddr == APB_PTR1) || (paddr == APB_PTR2) ||
    (paddr == APB_LASTADDR);
  assign apbWr = apbAccess && pwrite && apbMapped;
  assign pslverr = apbAccess && !apbMapped;

  always_comb begin
    if (paddr == APB_BANKSEL) begin
      prdata = {28'h0000000, bankSel_reg}; // RULE_02
    end else if (paddr == APB_WORK) begin
      prdata = {24'h000000, work_reg};
    end else if (paddr == APB_STATUS) begin
      prdata = {24'h000000, status_reg};
    end else if (paddr == APB_PTR0) begin
      prdata = {20'h00000, ptrVal[0]};
    end else if (paddr == APB_PTR1) begin
      prdata = {20'h00000, ptrVal[1]};
    end else if (paddr == APB_PTR2) begin
      prdata = {20'h00000, ptrVal[2]};
    end else if (paddr == APB_LASTADDR) begin
      prdata = {20'h00000, effAddr_reg};
    end else begin
      prdata = 32'h00000000;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bankSel_reg <= BANKSEL_RST[3:0];
    end else if (coreWr && (tgt == BANKSEL_ADDR)) begin
      bankSel_reg <= req.wrData[3:0]; // RULE_02
    end else if (loadBankValid) begin
      bankSel_reg <= loadBankLit[3:0]; // RULE_02
    end else if (apbWr && (paddr == APB_BANKSEL)) begin
      bankSel_reg <= pwdata[3:0]; // RULE_02
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      work_reg <= WORK_RST;
    end else if (coreWr && (tgt == WORK_ADDR)) begin
      work_reg <= req.wrData;
    end else if (apbWr && (paddr == APB_WORK)) begin
      work_reg <= pwdata[7:0];
    end
  end

  assign flagIn = flags.value ^
    (flags.subtract ? SUB_INVERT : 5'h00); // RULE_17

  // status: instruction flags beat a plain write; steps never touch it
  always_comb begin
    status_next = status_reg; // RULE_13
    if (req.valid && !(selfRef && req.write)) begin // RULE_09
      if (coreWr && (tgt == STATUS_ADDR)) begin
        status_next = req.wrData;
      end
      for (int i = 0; i < FLAG_W; i++) begin
        if (flags.mask[i]) begin
          status_next[i] = flagIn[i]; // RULE_16 RULE_03
        end
      end
      if (selfRef) begin
        status_next[ST_Z] = 1'b1; // RULE_09
      end
    end else if (apbWr && (paddr == APB_STATUS)) begin
      status_next = pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_reg <= STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= 8'h00;
      rdValid_reg <= 1'b0;
      effAddr_reg <= 12'h000;
    end else begin
      rdValid_reg <= req.valid && !req.write;
      if (req.valid) begin
        effAddr_reg <= tgt;
        if (!req.write) begin
          rdData_reg <= readMux;
        end
      end
    end
  end

  assign rdData = rdData_reg;
  assign rdValid = rdValid_reg;
  assign effAddr = effAddr_reg;
  assign statusOut = status_reg;

  sequence postIncReq;
    req.valid && opIsInd && (opSlot == SLOT_POSTINC) && (opPtr == 2'd0) &&
      !ptrWrLo[0] && !ptrWrHi[0];
  endsequence

  sequence stepped;
    ptr0 == $past(ptr0) + 12'h001;
  endsequence

  postIncStep_a: assert property (@(posedge clock) disable iff (!rstn)
    postIncReq |=> stepped) // RULE_10 RULE_14
    else $error("post-increment did not step pointer 0");

  postIncAddr_a: assert property (@(posedge clock) disable iff (!rstn)
    postIncReq |=> effAddr == $past(ptr0)) // RULE_10
    else $error("post-increment used the stepped address");

  directAddr_a: assert property (@(posedge clock) disable iff (!rstn)
    req.valid && !req.fullMode && req.accessBit && !isIndirect(dirAddr)
    |=> effAddr == {$past(bankSel_reg), $past(req.fileAddr)}) // RULE_01
    else $error("direct address not formed from bank selector");

  fullAddr_a: assert property (@(posedge clock) disable iff (!rstn)
    req.valid && req.fullMode && !isIndirect(req.fullAddr)
    |=> effAddr == $past(req.fullAddr)) // RULE_05
    else $error("full address move was banked");

  accessLow_a: assert property (@(posedge clock) disable iff (!rstn)
    req.valid && !req.fullMode && !req.accessBit &&
    (req.fileAddr < ACCESS_SPLIT)
    |=> effAddr[11:8] == ACCESS_LOW_BANK) // RULE_19 RULE_06
    else $error("access bank low part not in bank 0");

  bankHigh_a: assert property (@(posedge clock) disable iff (!rstn)
    req.valid && !req.write && !opIsInd && (dirAddr == BANKSEL_ADDR)
    |=> rdValid && (rdData[7:4] == 4'h0)) // RULE_02
    else $error("bank selector upper bits read nonzero");

  selfRead_a: assert property (@(posedge clock) disable iff (!rstn)
    req.valid && !req.write && selfRef
    |=> rdData == 8'h00 && status_reg[ST_Z]) // RULE_09
    else $error("self-referencing read not zero with zero flag");

  selfWrite_a: assert property (@(posedge clock) disable iff (!rstn)
    req.valid && req.write && selfRef |=> $stable(status_reg)) // RULE_09
    else $error("self-referencing write changed status");

  indexedHold_a: assert property (@(posedge clock) disable iff (!rstn)
    req.valid && !req.write && opIsInd && (opSlot == SLOT_INDEXED) &&
    (opPtr == 2'd0) |=> $stable(ptr0) && $stable(work_reg)) // RULE_12
    else $error("indexed access altered pointer or working value");

  stepNoFlags_a: assert property (@(posedge clock) disable iff (!rstn)
    req.valid && opIsInd && !selfRef && (flags.mask == 5'h00) && !req.write
    |=> $stable(status_reg)) // RULE_13
    else $error("pointer step changed status");

  flagGuard_a: assert property (@(posedge clock) disable iff (!rstn)
    coreWr && (tgt == STATUS_ADDR) && flags.mask[ST_Z]
    |=> status_reg[ST_Z] == $past(flagIn[ST_Z])) // RULE_16
    else $error("status write overrode an instruction flag");
endmodule : dmau_core

// *** src/dmau_pkg.sv ***
/*
  Shared constants and carrier types of the data-memory address unit:
  address map of the special registers, status flag positions, operand
  slot codes of the indirect pointers and the APB register map.
  Assumes an 8-bit core and a 12-bit, 4096-byte data space.
*/
package dmau_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_PTRS = 3;
  localparam int BANKS = 16;
  localparam int FLAG_W = 5;
  // access bank: low part of bank 0, then upper part of bank 15
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  // special function registers live from here upward
  localparam logic [11:0] SFR_BASE = 12'hFA0;
  localparam logic [11:0] STATUS_ADDR = 12'hFD8;
  localparam logic [11:0] WORK_ADDR = 12'hFD9;
  localparam logic [11:0] BANKSEL_ADDR = 12'hFDA;
  // pointer n owns eight addresses from PTR_BASE + 8*n
  localparam logic [11:0] PTR_BASE = 12'hFE0;
  localparam logic [11:0] PTR_END = 12'hFF8;
  localparam logic [7:0] BANKSEL_MASK = 8'h0F;
  localparam logic [7:0] BANKSEL_RST = 8'h00;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [11:0] PTR_RST = 12'h000;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_NC = 1;
  localparam int ST_Z = 2;
  localparam int ST_SW = 3;
  localparam int ST_N = 4;
  // carry and nibble carry are stored inverted on subtraction
  localparam logic [4:0] SUB_INVERT = 5'h03;
  // APB register map (byte addresses)
  localparam logic [11:0] APB_BANKSEL = 12'h000;
  localparam logic [11:0] APB_WORK = 12'h004;
  localparam logic [11:0] APB_STATUS = 12'h008;
  localparam logic [11:0] APB_PTR0 = 12'h00C;
  localparam logic [11:0] APB_PTR1 = 12'h010;
  localparam logic [11:0] APB_PTR2 = 12'h014;
  localparam logic [11:0] APB_LASTADDR = 12'h018;

  typedef enum logic [2:0] {
    SLOT_PLAIN = 3'b000,
    SLOT_POSTDEC = 3'b001,
    SLOT_POSTINC = 3'b010,
    SLOT_PREINC = 3'b011,
    SLOT_INDEXED = 3'b100,
    SLOT_LOW = 3'b101,
    SLOT_HIGH = 3'b110
  } dmau_slot_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic fullMode;
    logic accessBit;
    logic [7:0] fileAddr;
    logic [11:0] fullAddr;
    logic [7:0] wrData;
  } dmau_req_s;

  typedef struct packed {
    logic [4:0] mask;
    logic [4:0] value;
    logic subtract;
  } dmau_flags_s;
endpackage : dmau_pkg

// *** src/dmau_pointer.sv ***
/*
  One 12-bit indirect pointer held as a high and a low byte.
  Assumes the caller never asks for increment and decrement together.
*/
`timescale 1ns/1ps
module dmau_pointer
  import dmau_pkg::*;
(
  input wire logic clock, // device clock
  input wire logic rstn, // asynchronous reset, active low
  input wire logic wrLo, // core writes the low byte
  input wire logic wrHi, // core writes the high byte
  input wire logic [7:0] wrData, // byte write data
  input wire logic wrFull, // bus writes all 12 bits
  input wire logic [11:0] fullData, // bus write data
  input wire logic stepInc, // increment by one
  input wire logic stepDec, // decrement by one
  output logic [11:0] value // current pointer
);
  import dmau_pkg::*;

  logic [11:0] ptr_reg;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ptr_reg <= PTR_RST; // RULE_07
    end else if (wrLo || wrHi) begin
      // byte write beats any pending step
      if (wrLo) begin
        ptr_reg[7:0] <= wrData; // RULE_15
      end
      if (wrHi) begin
        ptr_reg[11:8] <= wrData[3:0]; // RULE_15
      end
    end else if (wrFull) begin
      ptr_reg <= fullData;
    end else if (stepInc) begin
      ptr_reg <= ptr_reg + 12'h001; // RULE_14
    end else if (stepDec) begin
      ptr_reg <= ptr_reg - 12'h001; // RULE_14
    end
  end

  assign value = ptr_reg;

  byteWins_a: assert property (@(posedge clock) disable iff (!rstn)
    wrLo && !wrHi && stepInc |=> ptr_reg[7:0] == $past(wrData)) // RULE_15
    else $error("pointer step overrode a byte write");
endmodule : dmau_pointer

// *** src/dmau_ram.sv ***
/*
  Banked static data RAM, sixteen banks of 256 bytes.
  Banks at or above IMPL_BANKS read zero and drop writes.
  Read is combinational, write on the rising clock edge.
*/
`timescale 1ns/1ps
module dmau_ram
  import dmau_pkg::*;
#(
  parameter int IMPL_BANKS = 16
) (
  input wire logic clock, // device clock
  input wire logic wrEn, // write strobe
  input wire logic [11:0] addr, // bank and offset
  input wire logic [7:0] wrData, // write data
  output logic [7:0] rdData // read data
);
  import dmau_pkg::*;

  logic [7:0] mem [0:BANKS*256-1];
  logic [4:0] bankNum;
  logic present;

  assign bankNum = {1'b0, addr[11:8]}; // RULE_04
  assign present = (32'(bankNum) < IMPL_BANKS); // RULE_03

  always_ff @(posedge clock) begin
    if (wrEn && present) begin
      mem[addr] <= wrData; // RULE_03
    end
  end

  assign rdData = present ? mem[addr] : 8'h00; // RULE_03
endmodule : dmau_ram

// *** tb/dmau_decoder_model.sv ***
/*
  Behavioural model of the instruction decoder and ALU in front of the
  address unit: one operand request or one bank load per call.
  Assumes callers run in the bench process, just past a rising edge.
*/
`timescale 1ns/1ps
module dmau_decoder_model
  import dmau_pkg::*;
(
  input wire logic clock, // device clock
  output dmau_pkg::dmau_req_s req, // operand request
  output dmau_pkg::dmau_flags_s flags, // alu flag results
  output logic loadBankValid, // bank load pulse
  output logic [7:0] loadBankLit // bank literal
);
  import dmau_pkg::*;
  initial begin
    req = '0;
    flags = '0;
    loadBankValid = 1'b0;
    loadBankLit = 8'h00;
  end

  // one cycle of request, then released lines show the inverse
  task automatic issue(input dmau_req_s r, input dmau_flags_s f);
    dmau_req_s idle;
    @(posedge clock);
    r.valid = 1'b1;
    req <= r;
    flags <= f;
    @(posedge clock);
    idle = ~r;
    idle.valid = 1'b0;
    req <= idle;
    flags <= ~f;
  endtask : issue

  task automatic load_bank(input logic [7:0] lit);
    @(posedge clock);
    loadBankValid <= 1'b1;
    loadBankLit <= lit;
    @(posedge clock);
    loadBankValid <= 1'b0;
    loadBankLit <= ~lit;
  endtask : load_bank
endmodule : dmau_decoder_model

// *** tb/tb_top.sv ***
/*
  Self-checking bench of the address unit: APB register access, direct,
  full and access-bank addressing, pointer slots and status protection.
  Assumes the decoder model sits on req, flags and the bank load port.
*/
`timescale 1ns/1ps
module tb_top;
  import dmau_pkg::*;
  localparam int IMPL = 14;
  logic clock = 1'b0;
  logic rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr, effAddr, p;
  logic [31:0] pwdata, prdata, rd;
  dmau_req_s req;
  dmau_flags_s flags;
  logic loadBankValid, rdValid;
  logic [7:0] loadBankLit, rdData, statusOut, fa, d, w;
  logic [3:0] b;
  int err_total = 0;
  int check_count = 0;
  int n, s;
  logic [31:0] stTab [4] = '{32'hFF1F00E0, 32'hFF1F0_1E3, 32'h00042_004,
    32'hA5003_EA5};

  always #2 clock = ~clock;

  dmau_core #(.IMPL_BANKS(IMPL)) i_dut (.clock(clock), .rstn(rstn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req(req), .flags(flags), .loadBankValid(loadBankValid),
    .loadBankLit(loadBankLit), .rdData(rdData), .rdValid(rdValid),
    .effAddr(effAddr), .statusOut(statusOut));
  dmau_decoder_model i_dec (.clock(clock), .req(req), .flags(flags),
    .loadBankValid(loadBankValid), .loadBankLit(loadBankLit));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // core operand access; outputs are sampled once the answer has landed
  task automatic op(input logic wr, full, ab, input logic [7:0] a8,
                    input logic [11:0] a12, input logic [7:0] dat,
                    input logic [10:0] f);
    i_dec.issue(dmau_req_s'({1'b0, wr, full, ab, a8, a12, dat}), f);
    #1;
  endtask : op

  function automatic logic [11:0] exp_eff(int sl, logic [11:0] pv,
                                          logic [7:0] wv);
    case (sl)
      3: return pv + 12'h001;
      4: return pv + {{4{wv[7]}}, wv};
      default: return pv;
    endcase
  endfunction : exp_eff

  function automatic logic [11:0] exp_ptr(int sl, logic [11:0] pv);
    case (sl)
      1: return pv - 12'h001;
      2, 3: return pv + 12'h001;
      default: return pv;
    endcase
  endfunction : exp_ptr

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(15237));
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
      chk(er, i == 7);
    end
    apb(1'b1, APB_BANKSEL, 32'hFFFFFFA5);
    apb(1'b0, APB_BANKSEL, 32'h0);
    chk(rd, 32'h05);
    $display("test registers done");
    for (int i = 0; i < 20; i++) begin
      b = 4'($urandom_range(1, IMPL - 1));
      fa = 8'($urandom);
      d = 8'($urandom);
      i_dec.load_bank({4'($urandom), b});
      op(1'b1, 1'b0, 1'b1, fa, 12'h0, d, 11'h0);
      chk(effAddr, {b, fa});
      chk(rdValid, 1'b0);
      op(1'b0, 1'b1, 1'b0, 8'h0, {b, fa}, 8'h0, 11'h0);
      chk(rdData, d);
      chk(rdValid, 1'b1);
      fa = 8'($urandom_range(0, 8'hDF));
      op(1'b0, 1'b0, 1'b0, fa, 12'h0, 8'h0, 11'h0);
      chk(effAddr, {(fa < ACCESS_SPLIT) ? 4'h0 : 4'hF, fa});
    end
    apb(1'b0, APB_BANKSEL, 32'h0);
    chk(rd, {28'h0, b});
    op(1'b0, 1'b1, 1'b0, 8'h0, BANKSEL_ADDR, 8'h0, 11'h0);
    chk(rdData, {4'h0, b});
    $display("test direct done");
    i_dec.load_bank(8'h0E);
    op(1'b1, 1'b0, 1'b1, fa, 12'h0, 8'h5A, {5'h1F, 5'h0B, 1'b0});
    chk(statusOut, 8'h0B);
    op(1'b0, 1'b1, 1'b0, 8'h0, {4'hE, fa}, 8'h0, 11'h0);
    chk(rdData, 8'h00);
    apb(1'b1, APB_STATUS, 32'h0);
    $display("test unimplemented done");
    for (int i = 0; i < 30; i++) begin
      n = $urandom_range(0, 2);
      s = (i < 2) ? 2 - i : $urandom_range(0, 4);
      p = (i < 2) ? 12'h0FF + 12'(i) : 12'($urandom_range(12'h080, 12'hD7F));
      w = 8'($urandom);
      d = 8'($urandom);
      apb(1'b1, APB_PTR0 + 12'(4 * n), 32'(p));
      apb(1'b1, APB_WORK, 32'(w));
      op(1'b1, 1'b1, 1'b0, 8'h0, PTR_BASE + 12'(8 * n + s), d, 11'h0);
      chk(effAddr, exp_eff(s, p, w));
      apb(1'b0, APB_PTR0 + 12'(4 * n), 32'h0);
      chk(rd, 32'(exp_ptr(s, p)));
      apb(1'b0, APB_WORK, 32'h0);
      chk(rd, 32'(w));
      op(1'b0, 1'b1, 1'b0, 8'h0, exp_eff(s, p, w), 8'h0, 11'h0);
      chk(rdData, d);
      chk(statusOut, 8'h00);
    end
    $display("test pointers done");
    apb(1'b1, APB_PTR1, 32'(PTR_BASE));
    op(1'b0, 1'b1, 1'b0, 8'h0, PTR_BASE + 12'h008, 8'h0, 11'h0);
    chk(rdData, 8'h00);
    chk(statusOut, 8'h04);
    op(1'b1, 1'b1, 1'b0, 8'h0, PTR_BASE + 12'h008, 8'h77, 11'h7FE);
    chk(statusOut, 8'h04);
    apb(1'b1, APB_PTR2, 32'hFF5);
    op(1'b1, 1'b1, 1'b0, 8'h0, PTR_BASE + 12'h012, 8'h40, 11'h0);
    apb(1'b0, APB_PTR2, 32'h0);
    chk(rd, 32'hF40);
    apb(1'b1, APB_PTR2, 32'hFF6);
    op(1'b1, 1'b1, 1'b0, 8'h0, PTR_BASE + 12'h011, 8'h03, 11'h0);
    apb(1'b0, APB_PTR2, 32'h0);
    chk(rd, 32'h3F6);
    apb(1'b1, APB_PTR0, 32'h200);
    op(1'b0, 1'b1, 1'b0, 8'h0, PTR_BASE + 12'h004, 8'h0, 11'h0);
    chk(effAddr, exp_eff(4, 12'h200, w));
    apb(1'b0, APB_PTR0, 32'h0);
    chk(rd, 32'h200);
    $display("test indirect corners done");
    // table rows: write data, mask, value, subtract, expected status
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 1'b1, 1'b0, 8'h0, STATUS_ADDR, stTab[i][31:24],
        {stTab[i][20:16], stTab[i][15:11], stTab[i][8]});
      chk(statusOut, stTab[i][7:0]);
    end
    $display("test status done");
    tally_and_finish();
  end
endmodule : tb_top
